// ---- rtl/csdec_pkg.sv ----
// constants and types for the control window and memory select decoder
// Functional notes
// - peripheral controls are 16-bit registers in one 256-byte window, memory or I/O.
// - window cycles run externally as normal but ignore external data and readies.
// - window base is 256-byte aligned; low eight base bits always zero.
// - relocation register at offset FEH supplies upper twelve base bits.
// - relocation bit 12 set maps window to memory, clear maps to I/O.
// - registers load all 16 bits at once, even from a byte write.
// - word write to relocation moves base on first cycle; prefer byte writes.
// - relocation register also holds slave-mode and escape-trap control bits.
// - reset loads relocation with 20FFH, window at FF00H in I/O space.
// - selects assert for every cycle in range, from core or DMA.
// - six memory selects over three regions: top, bottom, four mid-range; only top and bottom are built here.
// - region sizes powers of two 2K-128K; top and bottom add 1K, 256K.
// - top select when address bits 19-4 at or above limit, low six zero.
// - upper limit at A0H; only tabled patterns FFFBH..C03BH are legal.
// - after reset the top select covers 1K and works unprogrammed.
// - upper limit wait-control bits set ready mode for the top region.
// - lower limit at A2H, region starts at zero; patterns 0038H..3FF8H legal.
// - lower limit undefined after reset; bottom select idle until accessed.
// - bottom select when address bits 19-4 at or below limit, low six ones.
// - wait field: low two bits count waits, high bit ignores external ready.
// - honoured external ready overlaps internal waits; cycle takes the larger.
package csdec_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam logic [7:0] OFF_UPPER = 8'hA0;
  localparam logic [7:0] OFF_LOWER = 8'hA2;
  localparam logic [7:0] OFF_RELOC = 8'hFE;
  localparam logic [15:0] RELOC_RST = 16'h20FF;
  localparam logic [15:0] UPPER_RST = 16'hFFFB;
  localparam logic [15:0] LOWER_RST = 16'h0000;
  localparam int RELOC_MEM_BIT = 12;
  localparam int RELOC_ESC_BIT = 13;
  localparam int RELOC_SLAVE_BIT = 14;
  localparam int WAIT_IGN_BIT = 2;
  localparam int LIMIT_LO = 6;
  localparam logic [5:0] LIMIT_PAD_UP = 6'h00;
  localparam logic [5:0] LIMIT_PAD_LO = 6'h3F;
  localparam logic [1:0] WAIT_MAX = 2'h3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic mem;
    logic wr;
    logic rd;
    logic [DATA_W-1:0] wdata;
  } csdec_req_s;

  typedef enum {CS_IDLE, CS_WAIT} csdec_state_e;
endpackage

// ---- rtl/csdec_top.sv ----
// control window decode, top and bottom memory selects, wait-state ready
module csdec_top (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic CYC_START,
  input wire csdec_pkg::csdec_req_s BUS_REQ,
  input wire logic SYNC_READY_IN,
  input wire logic ASYNC_READY_IN,
  output logic CYC_DONE,
  output logic CTRL_HIT,
  output logic [csdec_pkg::DATA_W-1:0] CTRL_RDATA,
  output logic TOP_MEMORY_SELECT_N,
  output logic BOTTOM_MEMORY_SELECT_N,
  output logic CTRL_MEM_SPACE,
  output logic SLAVE_MODE,
  output logic ESC_TRAP
);
  import csdec_pkg::*;

  function automatic logic [15:0] limit_of(input logic [15:0] r, input logic [5:0] pad);
    limit_of = {r[15:LIMIT_LO], pad};
  endfunction

  csdec_state_e state_q;
  csdec_state_e state_d;
  logic [15:0] reloc_q;
  logic [15:0] upper_q;
  logic [15:0] lower_q;
  logic lower_en_q;
  logic hit_q;
  logic top_q;
  logic bot_q;
  logic [2:0] mode_q;
  logic [1:0] cnt_q;
  logic [15:0] rdata_q;

  wire idle_w = (state_q == CS_IDLE);
  wire take_w = CYC_START && idle_w;
  wire [7:0] off_w = BUS_REQ.addr[7:0];
  // base compared from bit 8 up only, so the window is always aligned
  wire win_addr_w = (BUS_REQ.addr[19:8] == reloc_q[11:0]);
  wire ctrl_hit_w = win_addr_w && (BUS_REQ.mem == reloc_q[RELOC_MEM_BIT]);
  wire access_w = take_w && ctrl_hit_w && (BUS_REQ.wr || BUS_REQ.rd);
  // only offset bits matter; odd offsets alias nothing and are left to software
  wire wr_hit_w = take_w && ctrl_hit_w && BUS_REQ.wr;
  wire wr_upper_w = wr_hit_w && (off_w == OFF_UPPER);
  wire wr_lower_w = wr_hit_w && (off_w == OFF_LOWER);
  wire wr_reloc_w = wr_hit_w && (off_w == OFF_RELOC);
  wire acc_lower_w = access_w && (off_w == OFF_LOWER);

  wire [15:0] addr_hi_w = BUS_REQ.addr[19:4];
  wire upper_hit_w = BUS_REQ.mem && (addr_hi_w >= limit_of(upper_q, LIMIT_PAD_UP));
  wire lower_hit_w = BUS_REQ.mem && lower_en_q
    && (addr_hi_w <= limit_of(lower_q, LIMIT_PAD_LO));

  wire [2:0] mode_w = upper_hit_w ? upper_q[2:0] :
                      lower_hit_w ? lower_q[2:0] : 3'h0;

  wire [15:0] rd_mux_w = (off_w == OFF_UPPER) ? upper_q :
                         (off_w == OFF_LOWER) ? lower_q :
                         (off_w == OFF_RELOC) ? reloc_q : 16'h0000;

  wire ext_rdy_w = SYNC_READY_IN || ASYNC_READY_IN;
  wire sel_any_w = top_q || bot_q;
  wire cnt_done_w = (cnt_q >= mode_q[1:0]);
  // external ready is ignored on window cycles, they end after one cycle
  wire done_w = (state_q == CS_WAIT) && (hit_q ||
    (sel_any_w ? (cnt_done_w && (mode_q[WAIT_IGN_BIT] || ext_rdy_w)) : ext_rdy_w));

  always_comb begin
    state_d = state_q;
    case (state_q)
      CS_IDLE: begin
        if (CYC_START) begin
          state_d = CS_WAIT;
        end
      end
      CS_WAIT: begin
        if (done_w) begin
          state_d = CS_IDLE;
        end
      end
      default: begin
        state_d = CS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= CS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // whole word loaded even when the external cycle carried one byte
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      reloc_q <= RELOC_RST;
    end else if (wr_reloc_w) begin
      reloc_q <= BUS_REQ.wdata;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      upper_q <= UPPER_RST;
    end else if (wr_upper_w) begin
      upper_q <= BUS_REQ.wdata;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      lower_q <= LOWER_RST;
    end else if (wr_lower_w) begin
      lower_q <= BUS_REQ.wdata;
    end
  end

  // contents are meaningless until touched, so the select stays off till then
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      lower_en_q <= 1'b0;
    end else if (acc_lower_w) begin
      lower_en_q <= 1'b1;
    end
  end

  // selects held for the whole cycle, whoever issued it
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      hit_q <= 1'b0;
      top_q <= 1'b0;
      bot_q <= 1'b0;
      mode_q <= 3'h0;
    end else if (take_w) begin
      hit_q <= ctrl_hit_w;
      top_q <= upper_hit_w;
      bot_q <= lower_hit_w;
      mode_q <= mode_w;
    end else if (done_w) begin
      hit_q <= 1'b0;
      top_q <= 1'b0;
      bot_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_q <= 2'h0;
    end else if (take_w) begin
      cnt_q <= 2'h0;
    end else if (!idle_w && !done_w && cnt_q != WAIT_MAX) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= 16'h0000;
    end else if (access_w && BUS_REQ.rd) begin
      rdata_q <= rd_mux_w;
    end
  end

  assign CYC_DONE = done_w;
  assign CTRL_HIT = hit_q;
  assign CTRL_RDATA = rdata_q;
  assign TOP_MEMORY_SELECT_N = ~top_q;
  assign BOTTOM_MEMORY_SELECT_N = ~bot_q;
  assign CTRL_MEM_SPACE = reloc_q[RELOC_MEM_BIT];
  assign SLAVE_MODE = reloc_q[RELOC_SLAVE_BIT];
  assign ESC_TRAP = reloc_q[RELOC_ESC_BIT];

  // checks
  sequence win_start_s;
    take_w && ctrl_hit_w;
  endsequence

  sequence win_done_s;
    CYC_DONE && CTRL_HIT;
  endsequence

  sequence reloc_write_s;
    take_w && ctrl_hit_w && BUS_REQ.wr && (off_w == OFF_RELOC);
  endsequence

  window_done_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    win_start_s |=> win_done_s
  ) else $error("window cycle did not end after one cycle");

  reloc_reset_a: assert property (
    @(posedge CORE_CLK)
    $rose(RESETN) |-> (reloc_q == RELOC_RST) && (upper_q == UPPER_RST) && !lower_en_q
  ) else $error("relocation or upper limit reset value wrong");

  reloc_load_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    reloc_write_s |=> (reloc_q == $past(BUS_REQ.wdata))
  ) else $error("relocation register not loaded as a word");

  io_nosel_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    take_w && !BUS_REQ.mem |=> TOP_MEMORY_SELECT_N && BOTTOM_MEMORY_SELECT_N
  ) else $error("memory select on an I/O cycle");

  lower_gate_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    !lower_en_q |-> BOTTOM_MEMORY_SELECT_N
  ) else $error("bottom select before lower limit accessed");

  upper_sel_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    take_w && BUS_REQ.mem && (BUS_REQ.addr[19:4] >= {upper_q[15:6], 6'h00})
      |=> !TOP_MEMORY_SELECT_N [*1] ##0 (state_q == CS_WAIT)
  ) else $error("top select missing in upper region");

  wait_hold_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (state_q == CS_WAIT) && !hit_q && sel_any_w && (cnt_q < mode_q[1:0]) |-> !CYC_DONE
  ) else $error("cycle ended before programmed waits");

  ignore_rdy_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    take_w && !ctrl_hit_w && upper_hit_w && upper_q[2]
      |-> ##[1:4] CYC_DONE
  ) else $error("ignoring-ready cycle did not end within wait count");

  overlap_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (state_q == CS_WAIT) && !hit_q && sel_any_w && !mode_q[2] && cnt_done_w && ext_rdy_w
      |-> CYC_DONE
  ) else $error("internal and external waits were added");

  sel_release_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    CYC_DONE |=> TOP_MEMORY_SELECT_N && BOTTOM_MEMORY_SELECT_N && (state_q == CS_IDLE)
  ) else $error("select held past end of cycle");

  sequence top_cycle_s;
    take_w && !ctrl_hit_w && upper_hit_w;
  endsequence

  sequence three_waits_s;
    !CYC_DONE [*3] ##1 CYC_DONE;
  endsequence

  cycle_hold_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (state_q == CS_WAIT) && !CYC_DONE |=> $stable({CTRL_HIT, TOP_MEMORY_SELECT_N, BOTTOM_MEMORY_SELECT_N})
  ) else $error("select or window flag changed inside a cycle");

  reloc_stable_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    !(take_w && ctrl_hit_w && BUS_REQ.wr && (off_w == OFF_RELOC)) |=> $stable(reloc_q)
  ) else $error("relocation register changed without a window write");

  win_base_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    take_w && (BUS_REQ.addr[19:8] != reloc_q[11:0]) |=> !CTRL_HIT
  ) else $error("window hit outside the relocated base");

  win_space_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    take_w && (BUS_REQ.mem != CTRL_MEM_SPACE) |=> !CTRL_HIT
  ) else $error("window hit in the wrong address space");

  upper_load_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    take_w && ctrl_hit_w && BUS_REQ.wr && (off_w == OFF_UPPER) |=> (upper_q == $past(BUS_REQ.wdata))
  ) else $error("upper limit not loaded as a word");

  lower_load_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    take_w && ctrl_hit_w && BUS_REQ.wr && (off_w == OFF_LOWER) |=> (lower_q == $past(BUS_REQ.wdata))
  ) else $error("lower limit not loaded as a word");

  lower_touch_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    take_w && ctrl_hit_w && (BUS_REQ.wr || BUS_REQ.rd) && (off_w == OFF_LOWER) |=> lower_en_q
  ) else $error("bottom select not enabled after lower limit access");

  upper_read_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    take_w && ctrl_hit_w && BUS_REQ.rd && (off_w == OFF_UPPER) |=> (CTRL_RDATA == $past(upper_q))
  ) else $error("upper limit read back wrong");

  lower_read_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    take_w && ctrl_hit_w && BUS_REQ.rd && (off_w == OFF_LOWER) |=> (CTRL_RDATA == $past(lower_q))
  ) else $error("lower limit read back wrong");

  unmapped_read_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    take_w && ctrl_hit_w && BUS_REQ.rd && (off_w != OFF_UPPER) && (off_w != OFF_LOWER) && (off_w != OFF_RELOC)
      |=> (CTRL_RDATA == 16'h0000)
  ) else $error("unmapped window offset read nonzero");

  lower_sel_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    take_w && BUS_REQ.mem && lower_en_q && (BUS_REQ.addr[19:4] <= {lower_q[15:6], 6'h3F})
      |=> !BOTTOM_MEMORY_SELECT_N
  ) else $error("bottom select missing in lower region");

  top_out_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    take_w && (BUS_REQ.addr[19:4] < {upper_q[15:6], 6'h00}) |=> TOP_MEMORY_SELECT_N
  ) else $error("top select below the upper limit");

  zero_wait_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    top_cycle_s ##0 (upper_q[2:0] == 3'h4) |=> CYC_DONE
  ) else $error("ignoring-ready cycle with no waits did not end at once");

  max_wait_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    top_cycle_s ##0 (upper_q[2:0] == 3'h7) |=> three_waits_s
  ) else $error("three wait states not inserted");
endmodule

// ---- test/csdec_bus_model.sv ----
// processor side bus model issuing core or dma cycles
module csdec_bus_model
  import csdec_pkg::*;
(
  input wire logic clk,
  output logic cyc_start,
  output csdec_pkg::csdec_req_s req,
  output logic synchronous_ready_input,
  output logic asynchronous_ready_input,
  input wire logic cyc_done,
  input wire logic hit,
  input wire logic top_n,
  input wire logic bot_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic s_hit;
  logic s_top;
  logic s_bot;
  initial begin
    cyc_start = 1'b0;
    req = '0;
    synchronous_ready_input = 1'b0;
    asynchronous_ready_input = 1'b0;
  end
  // one transfer; ext external not-ready cycles, odd counts use the async input
  task automatic cycle(input logic [19:0] a, input logic m, input logic w, input logic [15:0] d,
    input int ext, output int len);
    len = 0;
    @(posedge clk);
    #1;
    cyc_start = 1'b1;
    req = '{addr: a, mem: m, wr: w, rd: !w, wdata: d};
    @(posedge clk);
    #1;
    cyc_start = 1'b0;
    // released bus shows the inverse so a late sample is caught
    req = ~req;
    while (len < 12) begin
      synchronous_ready_input = (len >= ext) && !ext[0];
      asynchronous_ready_input = (len >= ext) && ext[0];
      #5;
      if (len == 0) begin
        s_hit = hit;
        s_top = top_n;
        s_bot = bot_n;
      end
      len++;
      if (cyc_done === 1'b1) break;
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    synchronous_ready_input = 1'b0;
    asynchronous_ready_input = 1'b0;
  endtask
endmodule

// ---- test/csdec_top_tb.sv ----
// self-checking bench for the window decoder and memory selects
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module csdec_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import csdec_pkg::*;
  logic clk, resetn, cyc_start, synchronous_ready_input, asynchronous_ready_input, cyc_done, hit, top_n, bot_n, mem_sp, slave, coprocessor_escape_opcode;
  logic [15:0] rdata;
  csdec_req_s req;
  int bad_count = 0;
  int cmp_count = 0;
  int len;
  csdec_top i_dut (.CORE_CLK(clk), .RESETN(resetn), .CYC_START(cyc_start), .BUS_REQ(req),
    .SYNC_READY_IN(synchronous_ready_input), .ASYNC_READY_IN(asynchronous_ready_input), .CYC_DONE(cyc_done), .CTRL_HIT(hit),
    .CTRL_RDATA(rdata), .TOP_MEMORY_SELECT_N(top_n), .BOTTOM_MEMORY_SELECT_N(bot_n),
    .CTRL_MEM_SPACE(mem_sp), .SLAVE_MODE(slave), .ESC_TRAP(coprocessor_escape_opcode));
  csdec_bus_model i_bus (.clk(clk), .cyc_start(cyc_start), .req(req), .synchronous_ready_input(synchronous_ready_input), .asynchronous_ready_input(asynchronous_ready_input),
    .cyc_done(cyc_done), .hit(hit), .top_n(top_n), .bot_n(bot_n));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // runs one cycle and judges its length in clocks
  task automatic xfer(input logic [19:0] a, input logic m, input logic w, input logic [15:0] d,
    input int ext, input int exp_len);
    i_bus.cycle(a, m, w, d, ext, len);
    `CHK(len, exp_len)
  endtask
  task automatic t_after_reset;
    `CHK({mem_sp, slave, coprocessor_escape_opcode, top_n, bot_n}, 5'b00111)
    xfer(20'h0FFFE, 1'b0, 1'b0, 16'h0000, 4, 1);
    `CHK(rdata, RELOC_RST)
    `CHK(i_bus.s_hit, 1'b1)
  endtask
  task automatic t_top;
    xfer(20'hFFFF0, 1'b1, 1'b0, 16'h0000, 0, 4);
    `CHK(i_bus.s_top, 1'b0)
    xfer(20'hFFBFF, 1'b1, 1'b0, 16'h0000, 2, 3);
    `CHK(i_bus.s_top, 1'b1)
    xfer(20'h0FFA0, 1'b0, 1'b1, 16'hF03B, 0, 1);
    xfer(20'hF0000, 1'b1, 1'b0, 16'h0000, 1, 4);
    `CHK(i_bus.s_top, 1'b0)
    xfer(20'hF0000, 1'b1, 1'b0, 16'h0000, 5, 6);
    xfer(20'h0FFA0, 1'b0, 1'b1, 16'hF03E, 0, 1);
    xfer(20'hFFFFF, 1'b1, 1'b0, 16'h0000, 6, 3);
    xfer(20'hEFFFF, 1'b1, 1'b0, 16'h0000, 0, 1);
    `CHK(i_bus.s_top, 1'b1)
    xfer(20'h0FFA0, 1'b0, 1'b1, 16'hC03F, 0, 1);
    xfer(20'hC0000, 1'b1, 1'b0, 16'h0000, 0, 4);
    `CHK(i_bus.s_top, 1'b0)
    xfer(20'hBFFFF, 1'b1, 1'b0, 16'h0000, 0, 1);
    `CHK(i_bus.s_top, 1'b1)
    xfer(20'h0FFA0, 1'b0, 1'b1, 16'hC03C, 0, 1);
    xfer(20'hFFFFF, 1'b1, 1'b0, 16'h0000, 5, 1);
  endtask
  task automatic t_bottom;
    xfer(20'h00000, 1'b1, 1'b0, 16'h0000, 1, 2);
    `CHK(i_bus.s_bot, 1'b1)
    xfer(20'h0FFA2, 1'b0, 1'b1, 16'h03F9, 0, 1);
    xfer(20'h03FFF, 1'b1, 1'b0, 16'h0000, 0, 2);
    `CHK(i_bus.s_bot, 1'b0)
    xfer(20'h04000, 1'b1, 1'b0, 16'h0000, 0, 1);
    `CHK(i_bus.s_bot, 1'b1)
    xfer(20'h00010, 1'b0, 1'b0, 16'h0000, 0, 1);
    `CHK(i_bus.s_bot, 1'b1)
    xfer(20'h0FFA4, 1'b0, 1'b0, 16'h0000, 0, 1);
    `CHK(rdata, 16'h0000)
    xfer(20'h0FFA2, 1'b0, 1'b0, 16'h0000, 0, 1);
    `CHK(rdata, 16'h03F9)
  endtask
  task automatic t_reloc;
    xfer(20'h0FFFE, 1'b0, 1'b1, 16'h50C0, 0, 1);
    `CHK({mem_sp, slave, coprocessor_escape_opcode}, 3'b110)
    // second half of a word write lands outside the moved window
    xfer(20'h0FFFF, 1'b0, 1'b1, 16'h50C0, 2, 3);
    `CHK(i_bus.s_hit, 1'b0)
    xfer(20'h0C0A0, 1'b1, 1'b0, 16'h0000, 0, 1);
    `CHK(rdata, 16'hC03C)
    xfer(20'h0C1A0, 1'b1, 1'b0, 16'h0000, 1, 2);
    `CHK(i_bus.s_hit, 1'b0)
    xfer(20'h0C0A0, 1'b0, 1'b0, 16'h0000, 1, 2);
    `CHK(i_bus.s_hit, 1'b0)
  endtask
  // generous limit: the sequence needs well under a thousand clocks
  initial begin
    #(40 * 5000);
    bad_count++;
    finish_test();
  end
  initial begin
    resetn = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_after_reset();
    t_top();
    t_bottom();
    t_reloc();
    finish_test();
  end
endmodule
